// [core/agis_pkg.sv]
// Package for the amplifier gain and input-select register bank.
// Assumes one 32-bit AHB-Lite slave port and a static analog front end.
package agis_pkg;

  // Register indices; byte address on the bus is four times the index
  localparam logic [7:0] IDX_GAIN = 8'h01;
  localparam logic [7:0] IDX_ROUTE = 8'h02;
  localparam logic [7:0] IDX_CHAN = 8'h03;
  localparam logic [31:0] ADDR_GAIN = 32'h0000_0004;
  localparam logic [31:0] ADDR_ROUTE = 32'h0000_0008;
  localparam logic [31:0] ADDR_CHAN = 32'h0000_000C;

  // Field positions (least significant bit of each field)
  localparam int REF_GAIN_LSB = 5;
  localparam int CONV_GAIN_LSB = 3;
  localparam int CHAN_GAIN_LSB = 0;
  localparam int SHORT_BIT = 6;
  localparam int ROUTE_LSB = 4;
  localparam int OFFSET_LSB = 1;
  localparam int NEG_SRC_LSB = 3;
  localparam int POS_SRC_LSB = 0;

  // Implemented bits of each register; the rest read as zero
  localparam logic [7:0] MASK_GAIN = 8'h7F;
  localparam logic [7:0] MASK_ROUTE = 8'h7E;
  localparam logic [7:0] MASK_CHAN = 8'h3F;

  // Power-on values
  localparam logic [7:0] RST_GAIN = 8'h00;
  localparam logic [7:0] RST_ROUTE = 8'h00;
  localparam logic [7:0] RST_CHAN = 8'h00;

  // Field codes
  localparam logic [1:0] REF_GAIN_RSVD = 2'h3;
  localparam logic [1:0] CONV_GAIN_MAX = 2'h1;
  localparam logic [2:0] CHAN_GAIN_RSVD = 3'h7;
  localparam logic [2:0] SRC_RSVD_A = 3'h2;
  localparam logic [2:0] SRC_RSVD_B = 3'h3;
  localparam logic [2:0] POS_RSVD_C = 3'h5;
  localparam logic [2:0] SRC_COMMON_MODE = 3'h6;
  localparam logic [2:0] SRC_TEMP_SENSE = 3'h7;

  // AHB transfer type bit that marks NONSEQ or SEQ
  localparam int HTRANS_ACTIVE_BIT = 1;

  // Static control lines into the analog front end
  typedef struct packed {
    logic [1:0] ref_gain_field;
    logic [1:0] conv_input_gain_field;
    logic [2:0] channel_gain_field;
    logic input_short_enable;
    logic [1:0] input_route_field;
    logic [2:0] input_offset_field;
    logic [2:0] neg_source_field;
    logic [2:0] pos_source_field;
  } agis_ctrl_t;

endpackage : agis_pkg

// [core/agis_regs.sv]
// Register bank of the programmable gain amplifier ahead of the converter.
// Assumes a single AHB-Lite master, word transfers only, and an analog
// front end that takes its control lines straight from these flip-flops.
//
// What this block does
// - Every converter input passes through the amplifier; no bypass exists.
// - Reference gain bits 6:5 pick unity, half or quarter; 11 is reserved.
// - Unimplemented bits of the three registers always read as zero.
// - Route bit 6 shorts the two selected input terminals when set.
// - Route bits 5:4 steer the selected inputs onto the amplifier pair.
// - Offset bits 3:1 give zero, plus or minus quarter steps of the unit.
// - The offset unit is the gain-scaled differential reference.
// - Negative source bits 5:3 pick pin one, pin three, DAC, ground, etc.
// - Positive source bits 2:0 pick pin zero, pin two, DAC, etc.
`timescale 1ns/1ps
`default_nettype none

module agis_regs
  import agis_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic [31:0] HRDATA,
  output logic HRESP,
  output agis_ctrl_t AMP_CTRL,
  output logic CFG_RESERVED
);

  // Whole state of the block in one record
  typedef struct packed {
    agis_ctrl_t ctrl;
    logic wr_pend;
    logic [7:0] wr_idx;
    logic [31:0] rdata;
    logic rdy;
    logic rsvd;
  } agis_state_t;

  agis_state_t s_q;
  agis_state_t s_d;

  // Map a byte address onto a register index; zero means unmapped
  function automatic logic [7:0] addr_idx(input logic [31:0] a);
    logic [7:0] idx;
    idx = 8'h00;
    if (a == ADDR_GAIN) begin
      idx = IDX_GAIN;
    end else if (a == ADDR_ROUTE) begin
      idx = IDX_ROUTE;
    end else if (a == ADDR_CHAN) begin
      idx = IDX_CHAN;
    end
    return idx;
  endfunction : addr_idx

  // Assemble the byte software sees; unimplemented bits forced low
  function automatic logic [7:0] read_reg(input agis_ctrl_t c,
                                          input logic [7:0] idx);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      IDX_GAIN: begin
        v[REF_GAIN_LSB +: 2] = c.ref_gain_field;
        v[CONV_GAIN_LSB +: 2] = c.conv_input_gain_field;
        v[CHAN_GAIN_LSB +: 3] = c.channel_gain_field;
        v = v & MASK_GAIN;
      end
      IDX_ROUTE: begin
        v[SHORT_BIT] = c.input_short_enable;
        v[ROUTE_LSB +: 2] = c.input_route_field;
        v[OFFSET_LSB +: 3] = c.input_offset_field;
        v = v & MASK_ROUTE;
      end
      IDX_CHAN: begin
        v[NEG_SRC_LSB +: 3] = c.neg_source_field;
        v[POS_SRC_LSB +: 3] = c.pos_source_field;
        v = v & MASK_CHAN;
      end
      default: begin
        v = 8'h00;
      end
    endcase
    return v;
  endfunction : read_reg

  // Store one written byte into the fields of the addressed register
  function automatic agis_ctrl_t write_reg(input agis_ctrl_t c,
                                           input logic [7:0] idx,
                                           input logic [7:0] d);
    agis_ctrl_t n;
    n = c;
    case (idx)
      IDX_GAIN: begin
        n.ref_gain_field = d[REF_GAIN_LSB +: 2];
        n.conv_input_gain_field = d[CONV_GAIN_LSB +: 2];
        n.channel_gain_field = d[CHAN_GAIN_LSB +: 3];
      end
      IDX_ROUTE: begin
        n.input_short_enable = d[SHORT_BIT];
        n.input_route_field = d[ROUTE_LSB +: 2];
        n.input_offset_field = d[OFFSET_LSB +: 3];
      end
      IDX_CHAN: begin
        n.neg_source_field = d[NEG_SRC_LSB +: 3];
        n.pos_source_field = d[POS_SRC_LSB +: 3];
      end
      default: begin
        n = c;
      end
    endcase
    return n;
  endfunction : write_reg

  // Reserved codes are stored as written but flagged for software
  function automatic logic any_reserved(input agis_ctrl_t c);
    logic r;
    r = 1'b0;
    if (c.ref_gain_field == REF_GAIN_RSVD) begin
      r = 1'b1;
    end
    if (c.conv_input_gain_field > CONV_GAIN_MAX) begin
      r = 1'b1;
    end
    if (c.channel_gain_field == CHAN_GAIN_RSVD) begin
      r = 1'b1;
    end
    if (c.neg_source_field == SRC_RSVD_A ||
        c.neg_source_field == SRC_RSVD_B) begin
      r = 1'b1;
    end
    if (c.pos_source_field == SRC_RSVD_A ||
        c.pos_source_field == SRC_RSVD_B ||
        c.pos_source_field == POS_RSVD_C) begin
      r = 1'b1;
    end
    return r;
  endfunction : any_reserved

  logic addr_ok;

  // Address phase is taken only when the bus is ready and we are selected
  assign addr_ok = HSEL && HREADY && HTRANS[HTRANS_ACTIVE_BIT];

  // Next state: data-phase write first, then the new address phase
  always_comb begin
    s_d = s_q;
    s_d.rdy = 1'b1; // Zero wait states, never stalls the master
    if (s_q.wr_pend) begin
      s_d.ctrl = write_reg(s_q.ctrl, s_q.wr_idx, HWDATA[7:0]);
    end
    s_d.wr_pend = 1'b0;
    if (addr_ok) begin
      if (HWRITE) begin
        s_d.wr_pend = 1'b1;
        s_d.wr_idx = addr_idx(HADDR);
      end else begin
        // Reads the updated fields so a read behind a write sees it
        s_d.rdata = {24'h00_0000, read_reg(s_d.ctrl, addr_idx(HADDR))};
      end
    end
    s_d.rsvd = any_reserved(s_d.ctrl);
  end

  // All state in one register; power-on values are zero except rdy, which resets high
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_q.ctrl <= agis_ctrl_t'({RST_GAIN[6:0], RST_ROUTE[6:1],
                                RST_CHAN[5:0]});
      s_q.wr_pend <= 1'b0;
      s_q.wr_idx <= 8'h00;
      s_q.rdata <= 32'h0000_0000;
      s_q.rdy <= 1'b1;
      s_q.rsvd <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // Fields go to the analog side with no gating; the converter only
  // ever sees the amplifier outputs, so there is no bypass control
  assign AMP_CTRL = s_q.ctrl;
  assign CFG_RESERVED = s_q.rsvd;
  assign HREADYOUT = s_q.rdy;
  assign HRDATA = s_q.rdata;
  assign HRESP = 1'b0;

  // Helper flags marking a data phase of each kind
  logic dp_wr_gain;
  logic dp_wr_route;
  logic dp_wr_chan;
  logic dp_rd;
  logic dp_any_wr;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      dp_wr_gain <= 1'b0;
      dp_wr_route <= 1'b0;
      dp_wr_chan <= 1'b0;
      dp_rd <= 1'b0;
      dp_any_wr <= 1'b0;
    end else begin
      dp_wr_gain <= addr_ok && HWRITE && HADDR == ADDR_GAIN;
      dp_wr_route <= addr_ok && HWRITE && HADDR == ADDR_ROUTE;
      dp_wr_chan <= addr_ok && HWRITE && HADDR == ADDR_CHAN;
      dp_rd <= addr_ok && !HWRITE;
      dp_any_wr <= addr_ok && HWRITE;
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  property p_ref_gain;
    dp_wr_gain |=> AMP_CTRL.ref_gain_field == $past(HWDATA[6:5]);
  endproperty
  a_ref_gain: assert property (p_ref_gain)
    else $error("reference gain field not taken from write");

  property p_conv_gain;
    dp_wr_gain |=> AMP_CTRL.conv_input_gain_field == $past(HWDATA[4:3]);
  endproperty
  a_conv_gain: assert property (p_conv_gain)
    else $error("converter gain field not taken from write");

  property p_chan_gain;
    dp_wr_gain ##1 !dp_wr_gain[*2] |->
      AMP_CTRL.channel_gain_field == $past(HWDATA[2:0], 2);
  endproperty
  a_chan_gain: assert property (p_chan_gain)
    else $error("channel gain field lost or changed");

  property p_unimpl_zero;
    dp_rd |-> HRDATA[31:8] == 24'h00_0000 && HRDATA[7] == 1'b0 &&
      !($past(HADDR) == ADDR_ROUTE && HRDATA[0]) &&
      !($past(HADDR) == ADDR_CHAN && HRDATA[6]);
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero)
    else $error("unimplemented bit read as one");

  property p_short;
    dp_wr_route |=> AMP_CTRL.input_short_enable == $past(HWDATA[6]);
  endproperty
  a_short: assert property (p_short)
    else $error("input short bit not taken from write");

  property p_route;
    dp_wr_route |=> AMP_CTRL.input_route_field == $past(HWDATA[5:4]);
  endproperty
  a_route: assert property (p_route)
    else $error("input route field not taken from write");

  property p_offset;
    dp_wr_route |=> AMP_CTRL.input_offset_field == $past(HWDATA[3:1]);
  endproperty
  a_offset: assert property (p_offset)
    else $error("offset field not taken from write");

  property p_neg_src;
    dp_wr_chan |=> AMP_CTRL.neg_source_field == $past(HWDATA[5:3]);
  endproperty
  a_neg_src: assert property (p_neg_src)
    else $error("negative source field not taken from write");

  property p_pos_src;
    dp_wr_chan |=> AMP_CTRL.pos_source_field == $past(HWDATA[2:0]);
  endproperty
  a_pos_src: assert property (p_pos_src)
    else $error("positive source field not taken from write");

  property p_hold;
    !dp_any_wr |=> $stable(AMP_CTRL);
  endproperty
  a_hold: assert property (p_hold)
    else $error("control lines changed without a write");

  property p_rsvd_flag;
    AMP_CTRL.channel_gain_field == CHAN_GAIN_RSVD |-> CFG_RESERVED;
  endproperty
  a_rsvd_flag: assert property (p_rsvd_flag)
    else $error("reserved channel gain not flagged");

  // Every reserved code must show on the flag, or software cannot tell
  property p_rsvd_ref;
    AMP_CTRL.ref_gain_field == REF_GAIN_RSVD |-> CFG_RESERVED;
  endproperty
  a_rsvd_ref: assert property (p_rsvd_ref)
    else $error("reserved reference gain not flagged");

  property p_rsvd_conv;
    AMP_CTRL.conv_input_gain_field > CONV_GAIN_MAX |-> CFG_RESERVED;
  endproperty
  a_rsvd_conv: assert property (p_rsvd_conv)
    else $error("reserved converter gain not flagged");

  property p_rsvd_neg;
    (AMP_CTRL.neg_source_field == SRC_RSVD_A ||
     AMP_CTRL.neg_source_field == SRC_RSVD_B) |-> CFG_RESERVED;
  endproperty
  a_rsvd_neg: assert property (p_rsvd_neg)
    else $error("reserved negative source not flagged");

  property p_rsvd_pos;
    (AMP_CTRL.pos_source_field == SRC_RSVD_A ||
     AMP_CTRL.pos_source_field == SRC_RSVD_B ||
     AMP_CTRL.pos_source_field == POS_RSVD_C) |-> CFG_RESERVED;
  endproperty
  a_rsvd_pos: assert property (p_rsvd_pos)
    else $error("reserved positive source not flagged");

  // All-zero fields are legal codes, so the flag must be low
  property p_rsvd_clear;
    AMP_CTRL == '0 |-> !CFG_RESERVED;
  endproperty
  a_rsvd_clear: assert property (p_rsvd_clear)
    else $error("flag raised with every field at zero");

  property p_always_ready;
    HREADYOUT && !HRESP;
  endproperty
  a_always_ready: assert property (p_always_ready)
    else $error("slave stalled or answered an error");

  c_write_gain: cover property (dp_wr_gain ##1 AMP_CTRL.ref_gain_field != 2'h0);
  c_temp_pair: cover property (AMP_CTRL.neg_source_field == SRC_TEMP_SENSE &&
                               AMP_CTRL.pos_source_field == SRC_TEMP_SENSE);
  c_read_chan: cover property (dp_rd && $past(HADDR) == ADDR_CHAN);
  c_wr_then_rd: cover property (dp_wr_route ##1 dp_rd);
  c_reserved: cover property ($rose(CFG_RESERVED));

endmodule : agis_regs

`default_nettype wire

// [dv/tb_amp_gain_input_select_regs.sv]
// Self-checking bench for the amplifier gain and input-select registers.
// Assumes agis_regs as the only AHB-Lite slave; HREADY loops from HREADYOUT.
`timescale 1ns/1ps
`default_nettype none
module tb_amp_gain_input_select_regs
  import agis_pkg::*;
;
  logic CLK, RST_N, HSEL, HWRITE, HREADYOUT, HRESP, CFG_RESERVED;
  logic [1:0] HTRANS;
  logic [2:0] HSIZE;
  logic [31:0] HADDR, HWDATA, HRDATA, rd;
  agis_ctrl_t AMP_CTRL;
  logic [7:0] mg, mr, mc;
  int mismatches, cmp_count;
  // Rows: {sel,htrans} nibble, byte address, write byte
  localparam int NR = 33;
  logic [19:0] rows [NR] = '{
    20'h6_0400, 20'h6_0429, 20'h6_0452, 20'h6_047B, 20'h6_04FC,
    20'h6_040D, 20'h6_040E, 20'h6_040F, 20'h6_08FF, 20'h6_0812,
    20'h6_0824, 20'h6_0846, 20'h6_0838, 20'h6_083A, 20'h6_083C,
    20'h6_0C00, 20'h6_0C09, 20'h6_0C12, 20'h6_0C1B, 20'h6_0C24,
    20'h6_0C2D, 20'h6_0C36, 20'h6_0CFF, 20'h6_0055, 20'h6_1055,
    20'h6_1455, 20'h2_0411, 20'h4_0811, 20'h5_0C11, 20'h6_0C36,
    20'h6_0C06, 20'h6_0C30,
    20'h6_0C3F};

  agis_regs uut (
    .CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRDATA(HRDATA),
    .HRESP(HRESP), .AMP_CTRL(AMP_CTRL), .CFG_RESERVED(CFG_RESERVED));

  // Free-running 50 MHz clock
  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end

  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  // Bounded wait; HREADYOUT read at the edge is the pre-edge value
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (HREADYOUT !== 1'b1 && n < 16);
    if (n >= 16)
      chk("hready", {31'h0, HREADYOUT}, 32'h0000_0001);
  endtask : wait_rdy

  // One transfer: address phase, then data phase; read data into rd
  task automatic xfer(input logic [3:0] ct, input logic [7:0] a,
                      input logic w, input logic [31:0] d);
    HSEL <= ct[2];
    HTRANS <= ct[1:0];
    HADDR <= {24'h00_0000, a};
    HWRITE <= w;
    wait_rdy();
    HTRANS <= 2'h0;
    HWDATA <= d;
    wait_rdy();
    rd = HRDATA;
  endtask : xfer

  // Reference model; only an active selected transfer may store
  task automatic mupd(input logic [3:0] ct, input logic [7:0] a,
                      input logic [7:0] d);
    if (ct[2] && ct[1])
      case (a)
        8'h04: mg = d & 8'h7F;
        8'h08: mr = d & 8'h7E;
        8'h0C: mc = d & 8'h3F;
        default: ;
      endcase
  endtask : mupd

  function automatic logic [7:0] mreg(input logic [7:0] a);
    case (a)
      8'h04: return mg;
      8'h08: return mr;
      8'h0C: return mc;
      default: return 8'h00;
    endcase
  endfunction : mreg

  task automatic chk_all(input string n);
    logic rs;
    logic [18:0] c;
    c = AMP_CTRL;
    rs = mg[6:5] == 2'h3 || mg[4] || mg[2:0] == 3'h7 ||
         mc[5:4] == 2'h1 || mc[2:1] == 2'h1 || mc[2:0] == 3'h5;
    chk({n, " gain"}, 32'(c[18:12]), 32'(mg[6:0]));
    chk({n, " route"}, 32'(c[11:6]), 32'(mr[6:1]));
    chk({n, " chan"}, 32'(c[5:0]), 32'(mc[5:0]));
    chk({n, " rsv"}, {31'h0, CFG_RESERVED}, {31'h0, rs});
    chk({n, " resp"}, {31'h0, HRESP}, 32'h0000_0000);
  endtask : chk_all

  // Main sequence: reset, table, then the awkward cases
  initial begin
    RST_N = 1'b0;
    HSEL = 1'b0;
    HTRANS = 2'h0;
    HADDR = 32'h0000_0000;
    HWRITE = 1'b0;
    HSIZE = 3'h2;
    HWDATA = 32'h0000_0000;
    {mg, mr, mc} = 24'h00_0000;
    mismatches = 0;
    cmp_count = 0;
    repeat (6) @(posedge CLK);
    chk_all("rst");
    RST_N <= 1'b1;
    @(posedge CLK);
    for (int a = 0; a < 16; a += 4) begin
      xfer(4'h6, 8'(a), 1'b0, 32'h0000_0000);
      chk("por", rd, 32'h0000_0000);
    end
    // Readback after every row also checks that unimplemented bits read as zero
    for (int i = 0; i < NR; i++) begin
      xfer(rows[i][19:16], rows[i][15:8], 1'b1,
           {24'hA5_A5A5, rows[i][7:0]});
      mupd(rows[i][19:16], rows[i][15:8], rows[i][7:0]);
      xfer(4'h6, rows[i][15:8], 1'b0, 32'h0000_0000);
      chk("read", rd, {24'h00_0000, mreg(rows[i][15:8])});
      chk_all("row");
    end
    // Write overlapped by a read of the same register
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= 1'b1;
    HADDR <= 32'h0000_000C;
    wait_rdy();
    HWRITE <= 1'b0;
    HWDATA <= 32'hFFFF_FFED;
    mc = 8'h2D;
    wait_rdy();
    HTRANS <= 2'h0;
    wait_rdy();
    chk("b2b", HRDATA, 32'h0000_002D);
    HSEL <= 1'b0;
    chk_all("b2b");
    // Reset again in mid-run: every field must clear
    RST_N <= 1'b0;
    {mg, mr, mc} = 24'h00_0000;
    @(posedge CLK);
    @(posedge CLK);
    chk_all("mid");
    RST_N <= 1'b1;
    @(posedge CLK);
    xfer(4'h6, 8'h0C, 1'b0, 32'h0000_0000);
    chk("mid rd", rd, 32'h0000_0000);
    end_sim();
  end

  // Watchdog: the run needs well under 1,000 cycles
  initial begin
    #400_000;
    mismatches++;
    end_sim();
  end
endmodule : tb_amp_gain_input_select_regs
`default_nettype wire
